// File: ofcr_pkg.sv
package ofcr_pkg;

  // Register word offsets
  localparam logic [7:0] ADDR_UNLOCK      = 8'h0a;
  localparam logic [7:0] ADDR_STATUS_PIN  = 8'h0f;
  localparam logic [7:0] ADDR_FRAME       = 8'h10;
  localparam logic [7:0] ADDR_PARITY      = 8'h11;
  localparam logic [7:0] ADDR_OFFSET_CALIBRATION_SELECT    = 8'h18;
  localparam logic [7:0] ADDR_MARGIN_VAL  = 8'h19;
  localparam logic [7:0] ADDR_MARGIN_EN   = 8'h1a;
  localparam logic [7:0] ADDR_HALF_MARGIN = 8'h1b;

  // Unlock key written to the unlock register
  localparam logic [7:0] UNLOCK_KEY       = 8'h55;

  // Writable-bit masks
  localparam logic [7:0] MASK_STATUS_PIN  = 8'h01;
  localparam logic [7:0] MASK_FRAME       = 8'h31;
  localparam logic [7:0] MASK_PARITY      = 8'h04;
  localparam logic [7:0] MASK_OFFSET_CALIBRATION_SELECT    = 8'h07;
  localparam logic [7:0] MASK_MARGIN_VAL  = 8'h1f;
  localparam logic [7:0] MASK_MARGIN_EN   = 8'h01;
  localparam logic [7:0] MASK_HALF_MARGIN = 8'h71;
  localparam logic [7:0] RESET_VALUE      = 8'h00;

  // Field positions
  localparam int BIT_STATUS_CFG  = 0;
  localparam int BIT_DEBUG       = 0;
  localparam int FMT_LO          = 4;
  localparam int BIT_PARITY_EN   = 2;
  localparam int BIT_MARGIN_EN   = 0;
  localparam int BIT_HALF_EN     = 0;
  localparam int HALF_OFST_LO    = 4;

  localparam logic [7:0] DEBUG_PATTERN = 8'ha6;

  // Frame lengths in bits
  localparam logic [5:0] LEN_RESULT = 6'h10;
  localparam logic [5:0] LEN_CHAN   = 6'h04;
  localparam logic [5:0] LEN_DEV    = 6'h04;

  typedef enum logic [1:0] {
    OFCR_FMT_RESULT   = 2'b00,
    OFCR_FMT_CHAN     = 2'b01,
    OFCR_FMT_CHAN_DEV = 2'b10,
    OFCR_FMT_RSVD     = 2'b11
  } ofcr_fmt_t;

endpackage

// File: ofcr_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ofcr_cfg_if;
  logic [7:0] status_pin;
  logic [7:0] frame;
  logic [7:0] parity;
  modport src (output status_pin, output frame, output parity);
  modport dst (input status_pin, input frame, input parity);
endinterface
`default_nettype wire

// File: ofcr_frame.sv
`timescale 1ns/1ps
`default_nettype none
module ofcr_frame (
  ofcr_cfg_if.dst        cfg,                 // Frame settings
  input  wire logic      output_lane_width_i, // 1 = two lanes
  input  wire logic      proc_friendly_i,     // Processor mode
  input  wire logic      seq_status_i,        // Sequence status
  output logic [5:0]     frame_len,           // Frame bits
  output logic           fmt_valid,           // Format not reserved
  output logic           sec_out,             // Secondary value
  output logic           sec_oe,              // Secondary enable
  output logic           debug_on             // Pattern select
);
  ofcr_pkg::ofcr_fmt_t fmt;
  logic [5:0]          base;

  assign fmt = ofcr_pkg::ofcr_fmt_t'(cfg.frame[ofcr_pkg::FMT_LO +: 2]);

  always_comb begin
    base      = ofcr_pkg::LEN_RESULT;
    fmt_valid = 1'b1;
    unique case (fmt)
      ofcr_pkg::OFCR_FMT_RESULT:   base = ofcr_pkg::LEN_RESULT;
      ofcr_pkg::OFCR_FMT_CHAN:     base = ofcr_pkg::LEN_RESULT
                                     + ofcr_pkg::LEN_CHAN;
      ofcr_pkg::OFCR_FMT_CHAN_DEV: base = ofcr_pkg::LEN_RESULT
                                     + ofcr_pkg::LEN_CHAN
                                     + ofcr_pkg::LEN_DEV;
      ofcr_pkg::OFCR_FMT_RSVD:     fmt_valid = 1'b0;
    endcase
  end

  // Padding only in processor mode; off means raw length
  always_comb begin
    frame_len = base + {5'h00, cfg.parity[ofcr_pkg::BIT_PARITY_EN]};
    if (!proc_friendly_i) begin
      frame_len = base + {5'h00, cfg.parity[ofcr_pkg::BIT_PARITY_EN]};
    end else if (frame_len > ofcr_pkg::LEN_RESULT) begin
      frame_len = 6'h20;
    end else begin
      frame_len = ofcr_pkg::LEN_RESULT;
    end
  end

  assign debug_on = cfg.frame[ofcr_pkg::BIT_DEBUG];

  // Single lane: secondary pin is status or released
  always_comb begin
    sec_out = 1'b0;
    sec_oe  = 1'b0;
    if (!output_lane_width_i) begin
      sec_oe  = cfg.status_pin[ofcr_pkg::BIT_STATUS_CFG];
      sec_out = seq_status_i & sec_oe;
    end
  end
endmodule
`default_nettype wire

// File: ofcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ofcr_regs (
  input  wire logic       clk_i,               // 100 MHz clock
  input  wire logic       arst_n_i,            // Async reset, low
  input  wire logic [7:0] addr_i,              // Register offset
  input  wire logic [7:0] wdata_i,             // Write data
  input  wire logic       wr_i,                // Write strobe
  input  wire logic       rd_i,                // Read strobe
  output logic      [7:0] rdata_o,             // Read data, next cycle
  input  wire logic       output_lane_width_i, // 0 = single lane
  input  wire logic       proc_friendly_i,     // Processor output mode
  input  wire logic       seq_status_i,        // Sequence status level
  input  wire logic       ext_ref_i,           // External reference used
  input  wire logic       frame_start_i,       // Start shifting a frame
  input  wire logic [15:0] result_i,           // Conversion result
  input  wire logic [3:0] channel_i,           // Channel identifier
  input  wire logic [3:0] dev_field_i,         // Device field
  output logic            primary_out_o,       // Primary serial output
  output logic            frame_busy_o,        // Frame shifting
  output logic            secondary_out_o,     // Secondary value
  output logic            secondary_oe_o,      // Secondary enable
  output logic      [2:0] ref_range_o,         // Offset cal range
  output logic      [4:0] ref_margin_o,        // Effective margin
  output logic      [2:0] half_margin_o,       // Half-ref margin
  output logic            half_margin_en_o,    // Half-ref enable
  output logic            unlocked_o           // Write access open
);

  ////////////////////////////////////////////////////////////////////////
  ofcr_cfg_if cfg ();
  logic [7:0] status_pin;
  logic [7:0] frame;
  logic [7:0] parity;
  logic [7:0] offset_calibration_select;
  logic [7:0] margin_val;
  logic [7:0] margin_en;
  logic [7:0] half_margin;
  logic       unlocked;
  logic [5:0] frame_len;
  logic       fmt_valid;
  logic       debug_on;
  logic       sec_out;
  logic       sec_oe;

  assign cfg.status_pin = status_pin;
  assign cfg.frame      = frame;
  assign cfg.parity     = parity;

  ofcr_frame u_frame (
    .cfg                 (cfg),
    .output_lane_width_i (output_lane_width_i),
    .proc_friendly_i     (proc_friendly_i),
    .seq_status_i        (seq_status_i),
    .frame_len           (frame_len),
    .fmt_valid           (fmt_valid),
    .sec_out             (sec_out),
    .sec_oe              (sec_oe),
    .debug_on            (debug_on)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = wr_i && (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Unlock: key opens, any other value closes again
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      unlocked <= 1'b0;
    end else if (hit(addr_i, ofcr_pkg::ADDR_UNLOCK)) begin
      unlocked <= (wdata_i == ofcr_pkg::UNLOCK_KEY);
    end
  end

  // Protected registers; masks keep reserved bits at zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_pin <= ofcr_pkg::RESET_VALUE;
      frame      <= ofcr_pkg::RESET_VALUE;
      parity     <= ofcr_pkg::RESET_VALUE;
    end else if (unlocked) begin
      if (hit(addr_i, ofcr_pkg::ADDR_STATUS_PIN)) begin
        status_pin <= wdata_i & ofcr_pkg::MASK_STATUS_PIN;
      end
      if (hit(addr_i, ofcr_pkg::ADDR_FRAME)) begin
        frame <= wdata_i & ofcr_pkg::MASK_FRAME;
      end
      if (hit(addr_i, ofcr_pkg::ADDR_PARITY)) begin
        parity <= wdata_i & ofcr_pkg::MASK_PARITY;
      end
    end
  end

  // Calibration registers, always writable
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      offset_calibration_select    <= ofcr_pkg::RESET_VALUE;
      margin_val  <= ofcr_pkg::RESET_VALUE;
      margin_en   <= ofcr_pkg::RESET_VALUE;
      half_margin <= ofcr_pkg::RESET_VALUE;
    end else begin
      if (hit(addr_i, ofcr_pkg::ADDR_OFFSET_CALIBRATION_SELECT)) begin
        offset_calibration_select <= wdata_i & ofcr_pkg::MASK_OFFSET_CALIBRATION_SELECT;
      end
      if (hit(addr_i, ofcr_pkg::ADDR_MARGIN_VAL)) begin
        margin_val <= wdata_i & ofcr_pkg::MASK_MARGIN_VAL;
      end
      if (hit(addr_i, ofcr_pkg::ADDR_MARGIN_EN)) begin
        margin_en <= wdata_i & ofcr_pkg::MASK_MARGIN_EN;
      end
      if (hit(addr_i, ofcr_pkg::ADDR_HALF_MARGIN)) begin
        half_margin <= wdata_i & ofcr_pkg::MASK_HALF_MARGIN;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port; unmapped offsets read zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        ofcr_pkg::ADDR_UNLOCK:      rdata_o <= {7'h00, unlocked};
        ofcr_pkg::ADDR_STATUS_PIN:  rdata_o <= status_pin;
        ofcr_pkg::ADDR_FRAME:       rdata_o <= frame;
        ofcr_pkg::ADDR_PARITY:      rdata_o <= parity;
        ofcr_pkg::ADDR_OFFSET_CALIBRATION_SELECT:    rdata_o <= offset_calibration_select;
        ofcr_pkg::ADDR_MARGIN_VAL:  rdata_o <= margin_val;
        ofcr_pkg::ADDR_MARGIN_EN:   rdata_o <= margin_en;
        ofcr_pkg::ADDR_HALF_MARGIN: rdata_o <= half_margin;
        default:                    rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Calibration outputs
  // Range only matters with an external reference
  assign ref_range_o = ext_ref_i ? offset_calibration_select[2:0] : 3'h0;
  assign ref_margin_o = margin_en[ofcr_pkg::BIT_MARGIN_EN]
                        ? margin_val[4:0] : 5'h00;
  assign half_margin_o    = half_margin[ofcr_pkg::HALF_OFST_LO +: 3];
  assign half_margin_en_o = half_margin[ofcr_pkg::BIT_HALF_EN];
  assign unlocked_o       = unlocked;

  ////////////////////////////////////////////////////////////////////////
  // Frame shifter on the primary output, MSB first
  logic [31:0] shreg;
  logic [5:0]  bits_left;
  logic [31:0] next_frame;
  logic [23:0] payload;
  logic [5:0]  plen;

  always_comb begin
    // Parity follows the data bits, ahead of any processor-mode padding
    plen    = ofcr_pkg::LEN_RESULT + ofcr_pkg::LEN_CHAN + ofcr_pkg::LEN_DEV;
    payload = {result_i, channel_i, dev_field_i};
    unique case (ofcr_pkg::ofcr_fmt_t'(frame[ofcr_pkg::FMT_LO +: 2]))
      ofcr_pkg::OFCR_FMT_RESULT: begin
        payload = {result_i, 8'h00};
        plen    = ofcr_pkg::LEN_RESULT;
      end
      ofcr_pkg::OFCR_FMT_CHAN: begin
        payload = {result_i, channel_i, 4'h0};
        plen    = ofcr_pkg::LEN_RESULT + ofcr_pkg::LEN_CHAN;
      end
      default:                   payload = {result_i, channel_i, dev_field_i};
    endcase
    if (debug_on) begin
      payload = {ofcr_pkg::DEBUG_PATTERN, 16'h0000};
    end
    next_frame = {payload, 8'h00};
    if (parity[ofcr_pkg::BIT_PARITY_EN]) begin
      // Even parity over the payload bits in use
      next_frame[31 - 32'(plen)] = ^payload;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shreg     <= 32'h0000_0000;
      bits_left <= 6'h00;
    end else if (frame_start_i && bits_left == 6'h00 && fmt_valid) begin
      shreg     <= next_frame;
      bits_left <= frame_len;
    end else if (bits_left != 6'h00) begin
      shreg     <= {shreg[30:0], 1'b0};
      bits_left <= bits_left - 6'h01;
    end
  end

  // Primary lane carries every bit in single-lane mode
  assign primary_out_o   = (bits_left != 6'h00) & shreg[31];
  assign frame_busy_o    = (bits_left != 6'h00);
  assign secondary_out_o = sec_out;
  assign secondary_oe_o  = sec_oe;
endmodule
`default_nettype wire

// File: ofcr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ofcr_regs_asserts (
  input wire logic       clk_i,               // Clock
  input wire logic       arst_n_i,            // Reset
  input wire logic [7:0] addr_i,              // Offset
  input wire logic [7:0] wdata_i,             // Data
  input wire logic       wr_i,                // Write
  input wire logic       rd_i,                // Read
  input wire logic [7:0] rdata_o,             // Read data
  input wire logic       output_lane_width_i, // Lanes
  input wire logic       seq_status_i,        // Status
  input wire logic       ext_ref_i,           // Ext ref
  input wire logic       frame_busy_o,        // Busy
  input wire logic       secondary_out_o,     // Sec value
  input wire logic       secondary_oe_o,      // Sec enable
  input wire logic [2:0] ref_range_o,         // Range
  input wire logic [4:0] ref_margin_o,        // Margin
  input wire logic [2:0] half_margin_o,       // Half margin
  input wire logic       half_margin_en_o,    // Half enable
  input wire logic       unlocked_o           // Unlocked
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_wr(logic [7:0] a);
    wr_i && addr_i == a;
  endsequence
  sequence s_key;
    wr_i && addr_i == 8'h0a && wdata_i == 8'h55;
  endsequence
  sequence s_busy8;
    frame_busy_o [*8];
  endsequence
  AST_UNLOCK: assert property (s_key |=> unlocked_o)
    else $error("unlock key not taken");
  AST_LOCK_HOLD: assert property (!(wr_i && addr_i == 8'h0a) |=>
    $stable(unlocked_o)) else $error("lock moved without write");
  AST_SEC: assert property (!output_lane_width_i && secondary_oe_o
    |-> secondary_out_o == seq_status_i) else $error("bad status pin");
  AST_PAR_RD: assert property ((wr_i || rd_i) && addr_i == 8'h11 |=>
    (rdata_o & 8'hfb) == 8'h00) else $error("parity reserved set");
  AST_BIT7: assert property (rdata_o[7] == 1'b0)
    else $error("reserved top bit set");
  AST_RANGE: assert property (s_wr(8'h18) ##1 ext_ref_i |->
    ($past(wdata_i) & 8'h07) == {5'h00, ref_range_o})
    else $error("range not stored");
  AST_MARGIN_OFF: assert property (wr_i && addr_i == 8'h1a &&
    !wdata_i[0] |=> ref_margin_o == 5'h00) else $error("margin leaks");
  AST_HALF: assert property (s_wr(8'h1b) |=>
    {1'b0, half_margin_o, 3'h0, half_margin_en_o} == ($past(wdata_i) &
    8'h71)) else $error("half margin not stored");
  AST_FMIN: assert property ($rose(frame_busy_o) |->
    s_busy8 ##1 s_busy8) else $error("frame too short");
  AST_FMAX: assert property ($rose(frame_busy_o) |->
    ##[16:33] !frame_busy_o) else $error("frame too long");
endmodule
bind ofcr_regs ofcr_regs_asserts u_chk (.*);
`default_nettype wire

// File: ofcr_host.sv
`timescale 1ns/1ps
`default_nettype none
module ofcr_host (
  input  wire logic       clk_i,     // Clock
  input  wire logic [7:0] rdata_i,   // Read data
  input  wire logic       ext_ref_i, // Ext ref fitted
  output logic      [7:0] addr_o,    // Offset
  output logic      [7:0] wdata_o,   // Data
  output logic            wr_o,      // Write
  output logic            rd_o       // Read
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h18 && !ext_ref_i) return;
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= (a == 8'h11) ? (d & 8'h04) : d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  // Data stands one cycle only, so take it just after that edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_i, arst_n_i, wr_i, rd_i, output_lane_width_i;
  logic        proc_friendly_i, seq_status_i, ext_ref_i, frame_start_i;
  logic [7:0]  addr_i, wdata_i, rdata_o;
  logic [15:0] result_i;
  logic [3:0]  channel_i, dev_field_i;
  logic        primary_out_o, frame_busy_o, secondary_out_o;
  logic        secondary_oe_o, half_margin_en_o, unlocked_o;
  logic [2:0]  ref_range_o, half_margin_o;
  logic [4:0]  ref_margin_o;
  int          err_total, n_checks, cyc;
  logic [7:0]  ad [7] = '{8'h0f, 8'h10, 8'h11, 8'h18, 8'h19, 8'h1a, 8'h1b};
  logic [7:0]  mk [7] = '{8'h01, 8'h31, 8'h04, 8'h07, 8'h1f, 8'h01, 8'h71};
  ofcr_regs uut (.*);
  ofcr_host host (.clk_i(clk_i), .rdata_i(rdata_o), .ext_ref_i(ext_ref_i),
    .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_lock;
    host.wr(8'h10, 8'h31);
    rchk(8'h10, 8'h00);
    chk(unlocked_o, 1'b0);
    host.wr(8'h0a, 8'h55);
    #1 chk(unlocked_o, 1'b1);
    host.wr(8'h10, 8'h31);
    rchk(8'h10, 8'h31);
    host.wr(8'h0a, 8'h00);
    host.wr(8'h11, 8'h04);
    rchk(8'h11, 8'h00);
    host.wr(8'h0a, 8'h55);
  endtask
  // All-ones writes expose any reserved bit that latches, except at 8'h11 where the host masks the data to 8'h04
  task automatic t_rsvd;
    for (int i = 0; i < 7; i++) begin
      host.wr(ad[i], 8'hff);
      rchk(ad[i], mk[i]);
    end
    host.wr(8'h05, 8'hff);
    rchk(8'h05, 8'h00);
  endtask
  task automatic t_sec;
    host.wr(8'h0f, 8'h00);
    #1 chk(secondary_oe_o, 1'b0);
    host.wr(8'h0f, 8'h01);
    seq_status_i <= 1'b1;
    #1 chk({secondary_oe_o, secondary_out_o}, 2'b11);
    @(posedge clk_i);
    seq_status_i <= 1'b0;
    #1 chk({secondary_oe_o, secondary_out_o}, 2'b10);
    @(posedge clk_i);
    output_lane_width_i <= 1'b1;
    #1 chk(secondary_oe_o, 1'b0);
    @(posedge clk_i);
    output_lane_width_i <= 1'b0;
  endtask
  task automatic t_cal;
    host.wr(8'h19, 8'h0b);
    host.wr(8'h1a, 8'h00);
    #1 chk(ref_margin_o, 5'h00);
    host.wr(8'h1a, 8'h01);
    #1 chk(ref_margin_o, 5'h0b);
    host.wr(8'h1b, 8'h51);
    #1 chk({half_margin_o, half_margin_en_o}, 4'hb);
    host.wr(8'h18, 8'h05);
    #1 chk(ref_range_o, 3'h5);
    @(posedge clk_i);
    ext_ref_i <= 1'b0;
    #1 chk(ref_range_o, 3'h0);
    host.wr(8'h18, 8'h02);
    @(posedge clk_i);
    ext_ref_i <= 1'b1;
    #1 chk(ref_range_o, 3'h5);
  endtask
  task automatic start;
    @(posedge clk_i);
    frame_start_i <= 1'b1;
    @(posedge clk_i);
    frame_start_i <= 1'b0;
    #1;
  endtask
  task automatic t_frame(input logic [7:0] f, input logic [7:0] p,
    input int len, input logic [15:0] top, input logic [15:0] m,
    input logic lsb);
    logic [39:0] v;
    int n;
    v = '0;
    n = 0;
    host.wr(8'h10, f);
    host.wr(8'h11, p);
    start();
    while (frame_busy_o === 1'b1 && n < 40) begin
      v = {v[38:0], primary_out_o};
      n++;
      @(posedge clk_i);
      #1;
    end
    chk(n, len);
    chk((v >> (n - 16)) & m, top);
    chk(v[0], lsb);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
  end
  initial begin
    {arst_n_i, output_lane_width_i, proc_friendly_i, seq_status_i} = '0;
    {ext_ref_i, frame_start_i} = 2'b10;
    result_i = 16'hc35a;
    channel_i = 4'h9;
    dev_field_i = 4'h3;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 7; i++) rchk(ad[i], 8'h00);
    t_lock();
    t_rsvd();
    t_sec();
    t_cal();
    t_frame(8'h00, 8'h00, 16, 16'hc35a, 16'hffff, 1'b0);
    t_frame(8'h10, 8'h00, 20, 16'hc35a, 16'hffff, 1'b1);
    t_frame(8'h20, 8'h00, 24, 16'hc35a, 16'hffff, 1'b1);
    // Odd payload weight, so the parity bit must be one
    @(posedge clk_i);
    channel_i <= 4'h8;
    t_frame(8'h20, 8'h04, 25, 16'hc35a, 16'hffff, 1'b1);
    t_frame(8'h01, 8'h00, 16, 16'ha600, 16'hff00, 1'b0);
    @(posedge clk_i);
    proc_friendly_i <= 1'b1;
    t_frame(8'h20, 8'h04, 32, 16'hc35a, 16'hffff, 1'b0);
    t_frame(8'h00, 8'h00, 16, 16'hc35a, 16'hffff, 1'b0);
    @(posedge clk_i);
    proc_friendly_i <= 1'b0;
    host.wr(8'h10, 8'h30);
    start();
    chk(frame_busy_o, 1'b0);
    results();
  end
endmodule
`default_nettype wire
